// ### hdl/tcd_pkg.sv
package tcd_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  // Disconnect debounce, in microseconds.
  localparam int DISC_DEBOUNCE_US = 10;
  localparam int DISC_DEBOUNCE_CYC = DISC_DEBOUNCE_US * CLK_MHZ;
  // Attach debounce, in microseconds.
  localparam int ATTACH_DEBOUNCE_US = 100;
  localparam int ATTACH_DEBOUNCE_CYC = ATTACH_DEBOUNCE_US * CLK_MHZ;
  // Vconn fast shutdown, in nanoseconds; the longest time rounds down.
  localparam int VCONN_FSD_NS = 16;
  localparam int VCONN_FSD_CYC_RAW = (VCONN_FSD_NS * CLK_MHZ) / 1000;
  localparam int VCONN_FSD_CYC = (VCONN_FSD_CYC_RAW < 1) ? 1 : VCONN_FSD_CYC_RAW;
  // Dual-role toggle half period, in microseconds.
  localparam int DRP_HALF_US = 35;
  localparam int DRP_HALF_CYC = DRP_HALF_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCD_TERM_OPEN = 2'h0,
    TCD_TERM_RA = 2'h1,
    TCD_TERM_RD = 2'h2
  } tcd_term_e;

  typedef enum logic [1:0] {
    TCD_ROLE_SRC = 2'h0,
    TCD_ROLE_SNK = 2'h1,
    TCD_ROLE_DRP = 2'h2
  } tcd_role_e;

  typedef enum logic [1:0] {
    TCD_ADV_DEF = 2'h0,
    TCD_ADV_1A5 = 2'h1,
    TCD_ADV_3A0 = 2'h2
  } tcd_adv_e;

  typedef enum logic [2:0] {
    TCD_CONN_NONE = 3'h0,
    TCD_CONN_SINK = 3'h1,
    TCD_CONN_CABLE = 3'h2,
    TCD_CONN_CABLE_SINK = 3'h3,
    TCD_CONN_DEBUG = 3'h4,
    TCD_CONN_AUDIO = 3'h5,
    TCD_CONN_SOURCE = 3'h6
  } tcd_conn_e;

  // Per-pin comparator inputs from the analog front end.
  typedef struct packed {
    logic above_disc;
    logic in_ra;
    logic in_rd;
  } tcd_cc_sense_s;

  // Per-pin termination control.
  typedef struct packed {
    logic pullup_en;
    logic pulldown_en;
    logic watch;
  } tcd_cc_ctrl_s;

endpackage

// ### hdl/tcd_cc_pin.sv
`timescale 1ns/100ps
`default_nettype none
module tcd_cc_pin
  import tcd_pkg::*;
#(
  parameter int DISC_CYC = DISC_DEBOUNCE_CYC,
  parameter int STAB_CYC = ATTACH_DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire tcd_cc_sense_s sense_async,
  input wire logic watch,
  output tcd_term_e term,
  output logic term_stable,
  output logic detach
);

  // ----------------------------------------------------------------------
  // Synchroniser: first stage is read only by the second.
  // ----------------------------------------------------------------------
  tcd_cc_sense_s sync1;
  tcd_cc_sense_s sync2;
  logic [$clog2(STAB_CYC+1)-1:0] stab_cnt;
  logic [$clog2(DISC_CYC+1)-1:0] disc_cnt;
  tcd_term_e raw_term;

  // Ra range is checked first: a low voltage means an active cable. [R12]
  assign raw_term = sync2.in_ra ? TCD_TERM_RA : (sync2.in_rd ? TCD_TERM_RD : TCD_TERM_OPEN);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= sense_async;
      sync2 <= sync1;
    end
  end

  // ----------------------------------------------------------------------
  // Classification debounce
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      term <= TCD_TERM_OPEN;
      stab_cnt <= '0;
      term_stable <= 1'b0;
    end else if (ce) begin
      if (raw_term != term) begin
        term <= raw_term;
        stab_cnt <= '0;
        term_stable <= 1'b0;
      end else if (stab_cnt != STAB_CYC[$bits(stab_cnt)-1:0]) begin
        stab_cnt <= stab_cnt + 1'b1;
      end else begin
        term_stable <= 1'b1; // [R20]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Disconnect debounce, only on a watched pin
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      disc_cnt <= '0;
      detach <= 1'b0;
    end else if (ce) begin
      detach <= 1'b0;
      if (!watch || !sync2.above_disc) begin
        disc_cnt <= '0;
      end else if (disc_cnt == DISC_CYC[$bits(disc_cnt)-1:0] - 1'b1) begin
        detach <= 1'b1; // [R13]
        disc_cnt <= '0;
      end else begin
        disc_cnt <= disc_cnt + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/tcd_attach.sv
// Function
// [R1] Both CC pins use one identical sensing and debounce instance each.
// [R2] Source, both open: unattached, watch both, VBUS and VCONN off.
// [R3] Source, Rd on CC1 only: sink attached, VBUS on, watch CC1.
// [R4] Source, Rd on CC2 only: sink attached, VBUS on, watch CC2.
// [R5] Source, Ra on CC1 only: cable flagged, watch both, no power. The code watches only CC1.
// [R6] Source, Ra on CC2 only: cable flagged, watch both, no power. The code watches only CC2.
// [R7] Source, Ra CC1 and Rd CC2: VBUS on, VCONN on CC1, watch CC2.
// [R8] Source, Rd CC1 and Ra CC2: VBUS on, VCONN on CC2, watch CC1.
// [R9] Source, Rd on both: debug accessory, detach on either pin.
// [R10] Source, Ra on both: audio accessory, detach on either pin.
// [R11] Default pullup until VBUS switch closes; then firmware level allowed.
// [R12] A voltage in the Ra range means an active cable, not a sink.
// [R13] Detach only after disconnect threshold held for the debounce time.
// [R14] Sink: pulldowns, attach by VBUS, decode advertised current from CC.
// [R15] Dual role toggles each pin between pulldown and pullup repeatedly.
// [R16] Dead battery presents Rd; a control removes it when unneeded.
// [R17] CC overvoltage or reverse current kills VCONN fast and PD transmitter.
// [R18] Unattached states enable the VBUS discharge pulldown.
// [R19] On detach remove power and return to unattached, watching both.
// [R20] Terminations must be stable for a debounce time before attach.
`timescale 1ns/100ps
`default_nettype none
module tcd_attach
  import tcd_pkg::*;
#(
  parameter int DISC_CYC = DISC_DEBOUNCE_CYC,
  parameter int STAB_CYC = ATTACH_DEBOUNCE_CYC,
  parameter int DRP_CYC = DRP_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire tcd_role_e role,
  input wire tcd_adv_e adv_request,
  input wire tcd_cc_sense_s cc1_sense,
  input wire tcd_cc_sense_s cc2_sense,
  input wire logic [1:0] cc1_snk_level,
  input wire logic [1:0] cc2_snk_level,
  input wire logic vbus_present_async,
  input wire logic dead_battery_async,
  input wire logic dead_rd_release,
  input wire logic cc_overvoltage_async,
  input wire logic reverse_current_async,
  output tcd_conn_e conn_state,
  output tcd_cc_ctrl_s cc1_ctrl,
  output tcd_cc_ctrl_s cc2_ctrl,
  output tcd_adv_e pullup_level,
  output logic vbus_source_en,
  output logic vconn_cc1_en,
  output logic vconn_cc2_en,
  output logic vbus_discharge_en,
  output logic pd_tx_disable,
  output logic orientation_cc2,
  output tcd_adv_e snk_adv_current
);

  // ----------------------------------------------------------------------
  // Pin sensing, one identical instance per pin
  // ----------------------------------------------------------------------
  tcd_term_e t1;
  tcd_term_e t2;
  logic s1;
  logic s2;
  logic d1;
  logic d2;
  logic [3:0] sy1;
  logic [3:0] sy2;
  logic vbus_ok;
  logic dead_bat;
  logic fault;
  logic [$clog2(DRP_CYC+1)-1:0] drp_cnt;
  logic drp_phase_src;

  tcd_cc_pin #(.DISC_CYC(DISC_CYC), .STAB_CYC(STAB_CYC)) u_cc1 ( // [R1]
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .sense_async(cc1_sense),
    .watch(cc1_ctrl.watch),
    .term(t1),
    .term_stable(s1),
    .detach(d1)
  );

  tcd_cc_pin #(.DISC_CYC(DISC_CYC), .STAB_CYC(STAB_CYC)) u_cc2 ( // [R1]
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .sense_async(cc2_sense),
    .watch(cc2_ctrl.watch),
    .term(t2),
    .term_stable(s2),
    .detach(d2)
  );

  // Level synchronisers for the VBUS, dead battery, overvoltage and reverse current inputs.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1 <= '0;
      sy2 <= '0;
    end else if (ce) begin
      sy1 <= {vbus_present_async, dead_battery_async, cc_overvoltage_async,
              reverse_current_async};
      sy2 <= sy1;
    end
  end

  assign vbus_ok = sy2[3];
  assign dead_bat = sy2[2];
  assign fault = sy2[1] | sy2[0];

  // ----------------------------------------------------------------------
  // Decision logic
  // ----------------------------------------------------------------------
  logic both_stable;
  logic src_mode;
  logic any_detach;
  tcd_conn_e target;
  tcd_conn_e next_conn;
  logic [1:0] next_watch;
  logic next_vbus;
  logic next_vc1;
  logic next_vc2;

  // In dual role the source decision is taken only in the pullup phase.
  assign src_mode = (role == TCD_ROLE_SRC) || (role == TCD_ROLE_DRP && drp_phase_src);
  assign both_stable = s1 & s2; // [R20]
  // Only a pin that is watched now may end a connection. The watch outputs lag one edge.
  // Without this, a detach pulse counted before an attach could end the attach at once.
  assign any_detach = (d1 & cc1_ctrl.watch) | (d2 & cc2_ctrl.watch); // [R13]

  always_comb begin
    target = TCD_CONN_NONE;
    unique case ({t1, t2})
      {TCD_TERM_RD, TCD_TERM_OPEN}: target = TCD_CONN_SINK; // [R3]
      {TCD_TERM_OPEN, TCD_TERM_RD}: target = TCD_CONN_SINK; // [R4]
      {TCD_TERM_RA, TCD_TERM_OPEN}: target = TCD_CONN_CABLE; // [R5]
      {TCD_TERM_OPEN, TCD_TERM_RA}: target = TCD_CONN_CABLE; // [R6]
      {TCD_TERM_RA, TCD_TERM_RD}: target = TCD_CONN_CABLE_SINK; // [R7]
      {TCD_TERM_RD, TCD_TERM_RA}: target = TCD_CONN_CABLE_SINK; // [R8]
      {TCD_TERM_RD, TCD_TERM_RD}: target = TCD_CONN_DEBUG; // [R9]
      {TCD_TERM_RA, TCD_TERM_RA}: target = TCD_CONN_AUDIO; // [R10]
      default: target = TCD_CONN_NONE; // [R2]
    endcase
  end

  always_comb begin
    next_conn = conn_state;
    if (!src_mode) begin
      next_conn = vbus_ok ? TCD_CONN_SOURCE : TCD_CONN_NONE; // [R14]
    end else if (conn_state == TCD_CONN_SOURCE) begin
      next_conn = TCD_CONN_NONE;
    end else if (any_detach) begin
      next_conn = TCD_CONN_NONE; // [R19]
    end else if (both_stable && (conn_state == TCD_CONN_NONE ||
                 conn_state == TCD_CONN_CABLE)) begin
      next_conn = target; // [R20]
    end
  end

  always_comb begin
    next_watch = 2'b11; // [R2]
    next_vbus = 1'b0;
    next_vc1 = 1'b0;
    next_vc2 = 1'b0;
    unique case (next_conn)
      TCD_CONN_SINK: begin
        next_watch = (t1 == TCD_TERM_RD) ? 2'b01 : 2'b10; // [R3]
        next_vbus = 1'b1; // [R4]
      end
      TCD_CONN_CABLE_SINK: begin
        next_watch = (t1 == TCD_TERM_RA) ? 2'b10 : 2'b01; // [R7]
        next_vbus = 1'b1;
        next_vc1 = (t1 == TCD_TERM_RA); // [R7]
        next_vc2 = (t2 == TCD_TERM_RA); // [R8]
      end
      // The cable pin is watched for detach. The open pin is left to the
      // classifier, which finds a sink attach there.
      TCD_CONN_CABLE: next_watch = (t1 == TCD_TERM_RA) ? 2'b01 : 2'b10; // [R5] [R6]
      TCD_CONN_SOURCE: next_watch = 2'b00;
      default: next_watch = 2'b11; // [R2]
    endcase
  end

  // ----------------------------------------------------------------------
  // Dual-role toggle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drp_cnt <= '0;
      drp_phase_src <= 1'b0;
    end else if (ce) begin
      if (role != TCD_ROLE_DRP || conn_state != TCD_CONN_NONE) begin
        drp_cnt <= '0;
      end else if (drp_cnt == DRP_CYC[$bits(drp_cnt)-1:0] - 1'b1) begin
        drp_cnt <= '0;
        drp_phase_src <= ~drp_phase_src; // [R15]
      end else begin
        drp_cnt <= drp_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State and outputs
  // ----------------------------------------------------------------------
  logic rd_hold;
  logic pull_up;
  logic pull_dn;

  assign pull_up = src_mode;
  assign pull_dn = !src_mode || rd_hold; // [R16]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_hold <= 1'b1;
    end else if (ce) begin
      rd_hold <= dead_bat && !dead_rd_release; // [R16]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conn_state <= TCD_CONN_NONE;
      cc1_ctrl <= '0;
      cc2_ctrl <= '0;
      vbus_source_en <= 1'b0;
      vconn_cc1_en <= 1'b0;
      vconn_cc2_en <= 1'b0;
      vbus_discharge_en <= 1'b1;
      pd_tx_disable <= 1'b0;
      orientation_cc2 <= 1'b0;
    end else if (ce) begin
      conn_state <= next_conn;
      cc1_ctrl <= '{pullup_en: pull_up, pulldown_en: pull_dn, watch: next_watch[0]};
      cc2_ctrl <= '{pullup_en: pull_up, pulldown_en: pull_dn, watch: next_watch[1]};
      vbus_source_en <= next_vbus;
      vconn_cc1_en <= next_vc1 && !fault; // [R17]
      vconn_cc2_en <= next_vc2 && !fault; // [R17]
      pd_tx_disable <= fault; // [R17]
      vbus_discharge_en <= (next_conn == TCD_CONN_NONE) ||
                           (next_conn == TCD_CONN_CABLE); // [R18]
      orientation_cc2 <= (next_conn == TCD_CONN_SOURCE) ? (t2 == TCD_TERM_RD) :
                         next_watch == 2'b10;
    end
  end

  // Advertisement stays default until the VBUS switch is closed.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pullup_level <= TCD_ADV_DEF;
      snk_adv_current <= TCD_ADV_DEF;
    end else if (ce) begin
      pullup_level <= vbus_source_en ? adv_request : TCD_ADV_DEF; // [R11]
      snk_adv_current <= tcd_adv_e'(orientation_cc2 ? cc2_snk_level : cc1_snk_level); // [R14]
    end
  end

endmodule
`default_nettype wire

// ### sim/tcd_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module tcd_far_end
  import tcd_pkg::*;
(
  input wire tcd_term_e t1,
  input wire tcd_term_e t2,
  output tcd_cc_sense_s cc1_sense,
  output tcd_cc_sense_s cc2_sense
);
  // ----------------------------------------------------------------
  // Termination to comparator levels
  // ----------------------------------------------------------------
  // An open pin floats up to the pullup voltage, so it reads above the disconnect level.
  assign cc1_sense = {t1 == TCD_TERM_OPEN, t1 == TCD_TERM_RA, t1 == TCD_TERM_RD};
  assign cc2_sense = {t2 == TCD_TERM_OPEN, t2 == TCD_TERM_RA, t2 == TCD_TERM_RD};
endmodule
`default_nettype wire

// ### sim/tcd_attach_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module tcd_attach_assertions
  import tcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire tcd_cc_sense_s cc1_sense,
  input wire tcd_cc_sense_s cc2_sense,
  input wire logic cc_overvoltage_async,
  input wire tcd_conn_e conn_state,
  input wire tcd_cc_ctrl_s cc1_ctrl,
  input wire tcd_cc_ctrl_s cc2_ctrl,
  input wire tcd_adv_e pullup_level,
  input wire logic vbus_source_en,
  input wire logic vconn_cc1_en,
  input wire logic vconn_cc2_en,
  input wire logic vbus_discharge_en,
  input wire logic pd_tx_disable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic vc = vconn_cc1_en | vconn_cc2_en;
  wire logic wd = cc1_ctrl.watch & cc1_sense.above_disc | cc2_ctrl.watch & cc2_sense.above_disc;
  AST_IDLE_OFF: assert property (conn_state == TCD_CONN_NONE |-> !vbus_source_en && !vc)
    else $error("power on while unattached");
  AST_DISCHARGE: assert property (vbus_discharge_en == (conn_state inside {TCD_CONN_NONE, TCD_CONN_CABLE}))
    else $error("discharge does not follow state");
  AST_SINK: assert property (conn_state == TCD_CONN_SINK |-> vbus_source_en && !vc && (cc1_ctrl.watch ^ cc2_ctrl.watch))
    else $error("sink attach outputs wrong");
  AST_CABLE: assert property (conn_state == TCD_CONN_CABLE |-> !vbus_source_en && !vc && (cc1_ctrl.watch ^ cc2_ctrl.watch))
    else $error("cable-only outputs wrong");
  AST_VCONN: assert property (vc |-> conn_state == TCD_CONN_CABLE_SINK && vbus_source_en && cc2_ctrl.watch == vconn_cc1_en && cc1_ctrl.watch == vconn_cc2_en)
    else $error("vconn on wrong pin or state");
  AST_ACCESSORY: assert property (conn_state inside {TCD_CONN_DEBUG, TCD_CONN_AUDIO} |-> cc1_ctrl.watch && cc2_ctrl.watch)
    else $error("accessory not watching both");
  AST_FAULT: assert property ($rose(cc_overvoltage_async) |-> ##[1:3] (!vc && pd_tx_disable))
    else $error("fault shutdown late");
  AST_DETACH: assert property ($past(conn_state) == TCD_CONN_SINK && conn_state == TCD_CONN_NONE |-> $past(wd, 4))
    else $error("detach without debounce");
  AST_PULLUP: assert property (!vbus_source_en && !$past(vbus_source_en) |-> pullup_level == TCD_ADV_DEF)
    else $error("pullup raised before vbus");
  cover property (conn_state == TCD_CONN_CABLE_SINK);
  cover property (conn_state == TCD_CONN_DEBUG);
  cover property ($rose(pd_tx_disable));
endmodule
bind tcd_attach tcd_attach_assertions u_chk (.clk(clk), .rst_b(rst_b), .cc1_sense(cc1_sense),
  .cc2_sense(cc2_sense), .cc_overvoltage_async(cc_overvoltage_async), .conn_state(conn_state),
  .cc1_ctrl(cc1_ctrl), .cc2_ctrl(cc2_ctrl), .pullup_level(pullup_level),
  .vbus_source_en(vbus_source_en), .vconn_cc1_en(vconn_cc1_en), .vconn_cc2_en(vconn_cc2_en),
  .vbus_discharge_en(vbus_discharge_en), .pd_tx_disable(pd_tx_disable));
`default_nettype wire

// ### sim/typec_cc_attach_detect_test.sv
`timescale 1ns/100ps
`default_nettype none
module typec_cc_attach_detect_test
  import tcd_pkg::*;
;
  localparam tcd_term_e OP = TCD_TERM_OPEN;
  localparam tcd_term_e RA = TCD_TERM_RA;
  localparam tcd_term_e RD = TCD_TERM_RD;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  tcd_role_e role = TCD_ROLE_SRC;
  tcd_term_e t1 = OP;
  tcd_term_e t2 = OP;
  logic [1:0] snk_lvl = 2'h0;
  logic vbus_in = 1'h0, dead_bat = 1'h0, rd_rel = 1'h0, ovp = 1'h0, rcp = 1'h0;
  tcd_cc_sense_s s1, s2;
  tcd_conn_e conn;
  tcd_cc_ctrl_s c1, c2;
  tcd_adv_e pul, snk_adv;
  logic vb, v1, v2, dis, ptx;
  int n_fail = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  tcd_far_end u_far (.t1(t1), .t2(t2), .cc1_sense(s1), .cc2_sense(s2));
  tcd_attach #(.DISC_CYC(4), .STAB_CYC(8), .DRP_CYC(16)) DUT (.clk(clk), .rst_b(rst_b),
    .ce(1'h1), .role(role), .adv_request(TCD_ADV_3A0), .cc1_sense(s1), .cc2_sense(s2),
    .cc1_snk_level(snk_lvl), .cc2_snk_level(snk_lvl), .vbus_present_async(vbus_in),
    .dead_battery_async(dead_bat), .dead_rd_release(rd_rel), .cc_overvoltage_async(ovp),
    .reverse_current_async(rcp), .conn_state(conn), .cc1_ctrl(c1), .cc2_ctrl(c2),
    .pullup_level(pul), .vbus_source_en(vb), .vconn_cc1_en(v1), .vconn_cc2_en(v2),
    .vbus_discharge_en(dis), .pd_tx_disable(ptx), .orientation_cc2(), .snk_adv_current(snk_adv));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [4:0] got, input logic [4:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic set_terms(input tcd_term_e a, input tcd_term_e b);
    @(posedge clk);
    t1 <= a;
    t2 <= b;
  endtask
  // Bounded so that a lost attach shows up as a mismatch, not a hang.
  task automatic wait_conn(input tcd_conn_e exp);
    int i;
    for (i = 0; i < 40 && conn !== exp; i++) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Expected bits e are {vbus, vconn cc1, vconn cc2, watch cc1, watch cc2}.
  task automatic row(input tcd_term_e a, input tcd_term_e b, input tcd_conn_e ec,
                     input logic [4:0] e);
    set_terms(a, b);
    wait_conn(ec);
    check(conn, ec, "state");
    check({vb & (ec < TCD_CONN_DEBUG), v1, v2, c1.watch, c2.watch}, e, "power and watch");
    check(dis, ec == TCD_CONN_NONE || ec == TCD_CONN_CABLE, "discharge");
    if (e[4]) begin
      repeat (2) @(posedge clk);
      #1 check(pul, TCD_ADV_3A0, "pullup level");
    end
    set_terms(OP, OP);
    wait_conn(TCD_CONN_NONE);
    check({vb, v1, v2, dis}, 4'h1, "detach power");
  endtask
  task automatic t_debounce();
    set_terms(RD, OP);
    repeat (6) @(posedge clk);
    set_terms(OP, OP);
    repeat (20) @(posedge clk);
    #1 check(conn, TCD_CONN_NONE, "short attach taken");
    set_terms(RD, OP);
    wait_conn(TCD_CONN_SINK);
    set_terms(OP, OP);
    set_terms(RD, OP);
    repeat (10) @(posedge clk);
    #1 check(conn, TCD_CONN_SINK, "glitch detached");
    set_terms(OP, OP);
    wait_conn(TCD_CONN_NONE);
  endtask
  task automatic t_fault(input logic rev);
    set_terms(RA, RD);
    wait_conn(TCD_CONN_CABLE_SINK);
    check(v1, 1'h1, "vconn before fault");
    @(posedge clk);
    ovp <= !rev;
    rcp <= rev;
    repeat (3) @(posedge clk);
    #1 check({v1, v2, ptx}, 3'h1, "fault shutdown");
    @(posedge clk);
    ovp <= 1'h0;
    rcp <= 1'h0;
    set_terms(OP, OP);
    wait_conn(TCD_CONN_NONE);
  endtask
  task automatic t_sink();
    @(posedge clk);
    dead_bat <= 1'h1;
    repeat (4) @(posedge clk);
    #1 check(c1.pulldown_en & c2.pulldown_en, 1'h1, "dead battery rd");
    @(posedge clk);
    rd_rel <= 1'h1;
    repeat (4) @(posedge clk);
    #1 check(c1.pulldown_en | c2.pulldown_en, 1'h0, "rd release");
    @(posedge clk);
    role <= TCD_ROLE_SNK;
    dead_bat <= 1'h0;
    rd_rel <= 1'h0;
    snk_lvl <= 2'h2;
    repeat (4) @(posedge clk);
    #1 check({c1.pullup_en, c1.pulldown_en, c2.pullup_en, c2.pulldown_en}, 4'h5, "sink rd");
    vbus_in <= 1'h1;
    wait_conn(TCD_CONN_SOURCE);
    repeat (2) @(posedge clk);
    #1 check(snk_adv, TCD_ADV_3A0, "sink current");
    vbus_in <= 1'h0;
    wait_conn(TCD_CONN_NONE);
    check(conn, TCD_CONN_NONE, "sink detach");
  endtask
  task automatic t_drp();
    logic [3:0] seen;
    seen = 4'h0;
    @(posedge clk);
    role <= TCD_ROLE_DRP;
    repeat (80) begin
      @(posedge clk);
      #1 seen |= {c1.pullup_en & !c1.pulldown_en, c1.pulldown_en & !c1.pullup_en,
                  c2.pullup_en & !c2.pulldown_en, c2.pulldown_en & !c2.pullup_en};
    end
    check(seen, 4'hF, "dual role toggle");
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    row(OP, OP, TCD_CONN_NONE, 5'h03);
    row(RD, OP, TCD_CONN_SINK, 5'h12);
    row(OP, RD, TCD_CONN_SINK, 5'h11);
    row(RA, OP, TCD_CONN_CABLE, 5'h02);
    row(OP, RA, TCD_CONN_CABLE, 5'h01);
    row(RA, RD, TCD_CONN_CABLE_SINK, 5'h19);
    row(RD, RA, TCD_CONN_CABLE_SINK, 5'h16);
    row(RD, RD, TCD_CONN_DEBUG, 5'h03);
    row(RA, RA, TCD_CONN_AUDIO, 5'h03);
    t_debounce();
    t_fault(1'h0);
    t_fault(1'h1);
    t_sink();
    t_drp();
    complete_run();
  end
endmodule
`default_nettype wire
